// [pmbus_status_reporting_test.sv]
// testbench: apb host end driving the device end over the link
`timescale 1ns/1ps
module pmbus_status_reporting_test
    import psr_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, st;
    logic [8:0]  ev;
    logic [7:0]  vendor_byte, cd;
    logic        hotswap_off, power_ok_pin, pec_error, frame_error, e, vss;
    logic [15:0] sw, w;
    logic [7:0]  msk [9] = '{8'h40, 8'h20, 8'h80, 8'h20, 8'h80, 8'h40,
                             8'h20, 8'h10, 8'h01};
    int          miscompares, checks_done;

    psr_link_if link ();
    psr_device_end psr_device_end_inst (
        .pclk(pclk), .presetn(presetn), .link(link),
        .vout_overvolt_warn(ev[0]), .vout_undervolt_warn(ev[1]),
        .iout_oc_shutdown(ev[2]), .iout_oc_warn(ev[3]),
        .overvolt_sense_pin(ev[4]), .vin_overvolt_warn(ev[5]),
        .vin_undervolt_warn(ev[6]), .undervolt_sense_pin(ev[7]),
        .input_overpower_warning(ev[8]),
        .vendor_status_register(vendor_byte), .hotswap_off(hotswap_off),
        .power_ok_pin(power_ok_pin), .pec_error(pec_error),
        .frame_error(frame_error), .vendor_status_summary(vss),
        .status_word(sw));
    psr_host_end psr_host_end_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link));
    psr_link_chk psr_link_chk_inst (
        .pclk(pclk), .presetn(presetn), .cmd_valid(link.cmd_valid),
        .cmd_ready(link.cmd_ready), .cmd_code(link.cmd_code),
        .clr_valid(link.clr_valid), .rsp_valid(link.rsp_valid),
        .rsp_data(link.rsp_data), .rsp_err(link.rsp_err));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, g, x);
        end
    endtask : chk

    // one apb transfer, entered and left at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic err);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // issue a link command, wait for done, fetch the answer
    task automatic cmd(input logic [7:0] c, output logic [31:0] r);
        apb(1'b1, PSR_OFF_CTRL, {22'h0, 2'b01, c}, r, e);
        st = '0;
        while (st[PSR_STAT_DONE] !== 1'b1 || st[PSR_STAT_BUSY] !== 1'b0)
            apb(1'b0, PSR_OFF_STAT, 32'h0, st, e);
        apb(1'b0, PSR_OFF_DATA, 32'h0, r, e);
    endtask : cmd

    task automatic clr;
        apb(1'b1, PSR_OFF_CTRL, 32'h0000_0200, q, e);
    endtask : clr

    initial begin
        #500us;
        miscompares++;
        tally_and_finish();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ev, vendor_byte, hotswap_off, pec_error, frame_error} = '0;
        power_ok_pin = 1'b1;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        cmd(PSR_CMD_STATUS_WORD, q);
        chk(q, 32'h0);
        for (int i = 0; i < 3; i++) begin
            cmd(8'(PSR_CMD_VOUT + i), q);
            chk(q, 32'h0);
        end
        for (int i = 0; i < 9; i++) begin
            cd = (i < 2) ? PSR_CMD_VOUT : (i < 4) ? PSR_CMD_IOUT
                                                  : PSR_CMD_INPUT;
            ev <= 9'(1 << i);
            @(posedge pclk);
            ev <= '0;
            repeat (2) @(posedge pclk);
            cmd(cd, q);
            chk(q, {24'h0, msk[i]});
            cmd(cd, q);
            chk(q, {24'h0, msk[i]});
            w = (16'h8000 >> (cd - PSR_CMD_VOUT)) | 16'h0001
                | (i == 2 ? 16'h0010 : 16'h0000)
                | (i == 7 ? 16'h0008 : 16'h0000);
            cmd(PSR_CMD_STATUS_WORD, q);
            chk(q, {16'h0, w});
            chk({16'h0, sw}, {16'h0, w});
            clr();
            cmd(cd, q);
            chk(q, 32'h0);
        end
        power_ok_pin <= 1'b0;
        hotswap_off  <= 1'b1;
        vendor_byte  <= 8'h05;
        @(posedge pclk);
        cmd(PSR_CMD_STATUS_WORD, q);
        chk(q, 32'h0000_1841);
        cmd(PSR_CMD_STATUS_BYTE, q);
        chk(q, 32'h0000_0041);
        cmd(PSR_CMD_VENDOR, q);
        chk(q, 32'h0000_0005);
        chk({31'h0, vss}, 32'h1);
        power_ok_pin <= 1'b1;
        hotswap_off  <= 1'b0;
        vendor_byte  <= 8'h00;
        @(posedge pclk);
        chk({31'h0, vss}, 32'h0);
        cmd(8'h55, q);
        chk({q[31:1], st[PSR_STAT_ERR]}, 32'h1);
        cmd(PSR_CMD_STATUS_BYTE, q);
        chk(q, 32'h0000_0002);
        for (int j = 0; j < 2; j++) begin
            clr();
            {frame_error, pec_error} <= 2'(1 << j);
            @(posedge pclk);
            {frame_error, pec_error} <= 2'b00;
            @(posedge pclk);
            cmd(PSR_CMD_STATUS_BYTE, q);
            chk(q, 32'h0000_0002);
        end
        // latch every bit, then reset mid-run: all must read zero again
        ev <= '1;
        @(posedge pclk);
        ev <= '0;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({16'h0, sw}, 32'h0);
        cmd(PSR_CMD_STATUS_WORD, q);
        chk(q, 32'h0);
        apb(1'b0, 12'hFFC, 32'h0, q, e);
        chk({q[31:1], e}, 32'h1);
        tally_and_finish();
    end
endmodule : pmbus_status_reporting_test

// [psr_device_end.sv]
// status reporting register group of the hot swap device
//
// Chosen here: the link device port; the APB slave port is in the host end.
`timescale 1ns/1ps
module psr_device_end
    import psr_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    psr_link_if.dev         link,
    input  wire logic       vout_overvolt_warn,
    input  wire logic       vout_undervolt_warn,
    input  wire logic       iout_oc_shutdown,
    input  wire logic       iout_oc_warn,
    input  wire logic       overvolt_sense_pin,
    input  wire logic       vin_overvolt_warn,
    input  wire logic       vin_undervolt_warn,
    input  wire logic       undervolt_sense_pin,
    input  wire logic       input_overpower_warning,
    input  wire logic [7:0] vendor_status_register,
    input  wire logic       hotswap_off,
    input  wire logic       power_ok_pin,
    input  wire logic       pec_error,
    input  wire logic       frame_error,
    output logic            vendor_status_summary,
    output logic [15:0]     status_word
);

    logic [7:0]  vout_set;
    logic [7:0]  iout_set;
    logic [7:0]  input_set;
    logic        cml_set;
    logic [7:0]  vout_q;
    logic [7:0]  iout_q;
    logic [7:0]  input_q;
    logic [0:0]  cml_q;
    logic [7:0]  status_byte;
    logic [15:0] word_live;
    logic        cmd_take;
    logic        rsp_valid_r;
    logic [15:0] rsp_data_r;
    logic        rsp_err_r;
    logic [15:0] status_word_r;

    // command decode: is the code one of the readable status commands
    function automatic logic psr_supported(input logic [7:0] code);
        return (code == PSR_CMD_STATUS_BYTE) ||
               (code == PSR_CMD_STATUS_WORD) ||
               (code == PSR_CMD_VOUT)        ||
               (code == PSR_CMD_IOUT)        ||
               (code == PSR_CMD_INPUT)       ||
               (code == PSR_CMD_VENDOR);
    endfunction : psr_supported

    // event sources into the sticky banks
    always_comb begin
        vout_set = '0;
        vout_set[PSR_V_OVW] = vout_overvolt_warn;
        vout_set[PSR_V_UVW] = vout_undervolt_warn;
    end

    always_comb begin
        iout_set = '0;
        iout_set[PSR_I_OCF] = iout_oc_shutdown;
        iout_set[PSR_I_OCW] = iout_oc_warn;
    end

    always_comb begin
        input_set = '0;
        input_set[PSR_N_OVF] = overvolt_sense_pin;
        input_set[PSR_N_OVW] = vin_overvolt_warn;
        input_set[PSR_N_UVW] = vin_undervolt_warn;
        input_set[PSR_N_UVF] = undervolt_sense_pin;
        input_set[PSR_N_OPW] = input_overpower_warning;
    end

    assign cmd_take = link.cmd_valid && link.cmd_ready;

    // unsupported command, bad pec or malformed message
    assign cml_set = pec_error || frame_error ||
                     (cmd_take && !psr_supported(link.cmd_code));

    // unused bit positions never get a set, so they read zero
    psr_sticky #(.W(8)) u_vout (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (vout_set),
        .clr     (link.clr_valid),
        .q       (vout_q)
    );

    psr_sticky #(.W(8)) u_iout (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (iout_set),
        .clr     (link.clr_valid),
        .q       (iout_q)
    );

    psr_sticky #(.W(8)) u_input (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (input_set),
        .clr     (link.clr_valid),
        .q       (input_q)
    );

    psr_sticky #(.W(1)) u_cml (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (cml_set),
        .clr     (link.clr_valid),
        .q       (cml_q)
    );

    assign vendor_status_summary = |vendor_status_register;

    // status byte, live and latched parts
    always_comb begin
        status_byte = PSR_BYTE_RST;
        status_byte[PSR_B_HSOFF] = hotswap_off;
        status_byte[PSR_B_OCF] = iout_q[PSR_I_OCF];
        status_byte[PSR_B_UVF] = input_q[PSR_N_UVF];
        status_byte[PSR_B_CML] = cml_q[0];
        status_byte[PSR_B_NOTA] = (|vout_q) || (|iout_q) ||
                                  (|input_q) ||
                                  vendor_status_summary;
    end

    // summary word, vout/iout/input bits from the latched banks, vendor and power bad live
    always_comb begin
        word_live = PSR_WORD_RST;
        word_live[PSR_W_VOUT] = |vout_q;
        word_live[PSR_W_IOUT] = |iout_q;
        word_live[PSR_W_INPUT] = |input_q;
        word_live[PSR_W_VENDOR] = vendor_status_summary;
        word_live[PSR_W_PBAD] = !power_ok_pin;
        word_live[7:0] = status_byte;
    end

    // registered copy of the summary word for local monitoring
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_word_r <= PSR_WORD_RST;
        end else begin
            status_word_r <= word_live;
        end
    end

    assign status_word = status_word_r;

    // always ready; answer one cycle after the command is taken
    assign link.cmd_ready = 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_valid_r <= 1'b0;
        end else begin
            rsp_valid_r <= cmd_take;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_err_r <= 1'b0;
        end else if (cmd_take) begin
            rsp_err_r <= !psr_supported(link.cmd_code);
        end
    end

    // read data mux, byte commands zero extended
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_data_r <= PSR_WORD_RST;
        end else if (cmd_take) begin
            unique case (link.cmd_code)
                PSR_CMD_STATUS_BYTE: rsp_data_r <= {8'h00, status_byte};
                PSR_CMD_STATUS_WORD: rsp_data_r <= word_live;
                PSR_CMD_VOUT:        rsp_data_r <= {8'h00, vout_q};
                PSR_CMD_IOUT:        rsp_data_r <= {8'h00, iout_q};
                PSR_CMD_INPUT:       rsp_data_r <= {8'h00, input_q};
                PSR_CMD_VENDOR:      rsp_data_r <= {8'h00,
                                                    vendor_status_register};
                default:             rsp_data_r <= PSR_WORD_RST;
            endcase
        end
    end

    assign link.rsp_valid = rsp_valid_r;
    assign link.rsp_data  = rsp_data_r;
    assign link.rsp_err   = rsp_err_r;

endmodule : psr_device_end

// [psr_host_end.sv]
// apb-controlled host that reads status commands over the link
`timescale 1ns/1ps
module psr_host_end
    import psr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    psr_link_if.host         link
);

    typedef enum logic [1:0] {
        PSR_IDLE = 2'b00,
        PSR_REQ  = 2'b01,
        PSR_WAIT = 2'b10
    } psr_state_t;

    psr_state_t  state_r;
    logic [7:0]  code_r;
    logic        clr_r;
    logic        done_r;
    logic        err_r;
    logic [15:0] data_r;
    logic        acc;
    logic        wr_ctrl;
    logic        go;
    logic        mapped;

    assign acc     = psel && penable;
    assign mapped  = (paddr == PSR_OFF_CTRL) || (paddr == PSR_OFF_STAT) ||
                     (paddr == PSR_OFF_DATA);
    assign wr_ctrl = acc && pwrite && (paddr == PSR_OFF_CTRL);
    assign go      = wr_ctrl && pwdata[PSR_CTRL_GO] && (state_r == PSR_IDLE);
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;

    // command sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= PSR_IDLE;
        end else begin
            unique case (state_r)
                PSR_IDLE: if (go) state_r <= PSR_REQ;
                PSR_REQ:  if (link.cmd_ready) state_r <= PSR_WAIT;
                PSR_WAIT: if (link.rsp_valid) state_r <= PSR_IDLE;
                default:  state_r <= PSR_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_r <= PSR_BYTE_RST;
        end else if (go) begin
            code_r <= pwdata[7:0];
        end
    end

    // fault clear strobe, one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_r <= 1'b0;
        end else begin
            clr_r <= wr_ctrl && pwdata[PSR_CTRL_CLR];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
            err_r  <= 1'b0;
            data_r <= PSR_WORD_RST;
        end else if (go) begin
            done_r <= 1'b0;
        end else if (state_r == PSR_WAIT && link.rsp_valid) begin
            done_r <= 1'b1;
            err_r  <= link.rsp_err;
            data_r <= link.rsp_data;
        end
    end

    assign link.cmd_valid = (state_r == PSR_REQ);
    assign link.cmd_code  = code_r;
    assign link.clr_valid = clr_r;

    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            if (paddr == PSR_OFF_CTRL) begin
                prdata[7:0] = code_r;
            end else if (paddr == PSR_OFF_STAT) begin
                prdata[PSR_STAT_BUSY] = (state_r != PSR_IDLE);
                prdata[PSR_STAT_DONE] = done_r;
                prdata[PSR_STAT_ERR]  = err_r;
            end else if (paddr == PSR_OFF_DATA) begin
                prdata[15:0] = data_r;
            end
        end
    end

endmodule : psr_host_end

// [psr_link_chk.sv]
// concurrent checks on the status link between host and device
`timescale 1ns/1ps
module psr_link_chk
    import psr_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        cmd_valid,
    input wire logic        cmd_ready,
    input wire logic [7:0]  cmd_code,
    input wire logic        clr_valid,
    input wire logic        rsp_valid,
    input wire logic [15:0] rsp_data,
    input wire logic        rsp_err
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_answer;
        cmd_valid && cmd_ready |=> rsp_valid;
    endproperty
    a_answer: assert property (p_answer)
        else $error("no answer one cycle after command");
    property p_no_stray;
        rsp_valid |-> $past(cmd_valid && cmd_ready);
    endproperty
    a_no_stray: assert property (p_no_stray)
        else $error("answer without command");
    property p_word_rsvd;
        rsp_valid && $past(cmd_code) == PSR_CMD_STATUS_WORD
            |-> rsp_data[10:8] == 3'b000;
    endproperty
    a_word_rsvd: assert property (p_word_rsvd)
        else $error("summary word reserved bits set");
    property p_vout_rsvd;
        rsp_valid && $past(cmd_code) == PSR_CMD_VOUT
            |-> rsp_data[15:7] == '0 && rsp_data[4:0] == '0;
    endproperty
    a_vout_rsvd: assert property (p_vout_rsvd)
        else $error("vout reserved bits set");
    property p_iout_rsvd;
        rsp_valid && $past(cmd_code) == PSR_CMD_IOUT
            |-> rsp_data[15:8] == '0 && !rsp_data[6] && rsp_data[4:0] == '0;
    endproperty
    a_iout_rsvd: assert property (p_iout_rsvd)
        else $error("iout reserved bits set");
    property p_input_rsvd;
        rsp_valid && $past(cmd_code) == PSR_CMD_INPUT
            |-> rsp_data[15:8] == '0 && rsp_data[3:1] == 3'b000;
    endproperty
    a_input_rsvd: assert property (p_input_rsvd)
        else $error("input reserved bits set");
    property p_known_ok;
        rsp_valid && $past(cmd_code) inside {[8'h79:8'h7C]} |-> !rsp_err;
    endproperty
    a_known_ok: assert property (p_known_ok)
        else $error("status command flagged as error");
    property p_bad_code;
        rsp_valid && !($past(cmd_code) inside {[8'h78:8'h7C], 8'h80})
            |-> rsp_err && rsp_data == '0;
    endproperty
    a_bad_code: assert property (p_bad_code)
        else $error("unsupported code not flagged");
    property p_clr_pulse;
        clr_valid |=> !clr_valid;
    endproperty
    a_clr_pulse: assert property (p_clr_pulse)
        else $error("clear strobe longer than one cycle");
endmodule : psr_link_chk

// [psr_link_if.sv]
// link between the status reporting device and its host controller
`timescale 1ns/1ps
interface psr_link_if;
    logic        cmd_valid;
    logic        cmd_ready;
    logic [7:0]  cmd_code;
    logic        clr_valid;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic        rsp_err;

    modport dev (
        input  cmd_valid,
        output cmd_ready,
        input  cmd_code,
        input  clr_valid,
        output rsp_valid,
        output rsp_data,
        output rsp_err
    );

    modport host (
        output cmd_valid,
        input  cmd_ready,
        output cmd_code,
        output clr_valid,
        input  rsp_valid,
        input  rsp_data,
        input  rsp_err
    );
endinterface : psr_link_if

// [psr_pkg.sv]
// shared constants for the power status reporting block
package psr_pkg;

    // status command codes on the management link
    localparam logic [7:0] PSR_CMD_STATUS_BYTE = 8'h78;
    localparam logic [7:0] PSR_CMD_STATUS_WORD = 8'h79;
    localparam logic [7:0] PSR_CMD_VOUT        = 8'h7A;
    localparam logic [7:0] PSR_CMD_IOUT        = 8'h7B;
    localparam logic [7:0] PSR_CMD_INPUT       = 8'h7C;
    localparam logic [7:0] PSR_CMD_VENDOR      = 8'h80;

    // reset values
    localparam logic [15:0] PSR_WORD_RST = 16'h0000;
    localparam logic [7:0]  PSR_BYTE_RST = 8'h00;

    // summary word bit positions
    localparam int PSR_W_VOUT   = 15;
    localparam int PSR_W_IOUT   = 14;
    localparam int PSR_W_INPUT  = 13;
    localparam int PSR_W_VENDOR = 12;
    localparam int PSR_W_PBAD   = 11;

    // status byte bit positions
    localparam int PSR_B_HSOFF = 6;
    localparam int PSR_B_OCF   = 4;
    localparam int PSR_B_UVF   = 3;
    localparam int PSR_B_CML   = 1;
    localparam int PSR_B_NOTA  = 0;

    // output voltage / current status bit positions
    localparam int PSR_V_OVW  = 6;
    localparam int PSR_V_UVW  = 5;
    localparam int PSR_I_OCF  = 7;
    localparam int PSR_I_OCW  = 5;

    // input status bit positions
    localparam int PSR_N_OVF  = 7;
    localparam int PSR_N_OVW  = 6;
    localparam int PSR_N_UVW  = 5;
    localparam int PSR_N_UVF  = 4;
    localparam int PSR_N_OPW  = 0;

    // host controller apb map
    localparam logic [11:0] PSR_OFF_CTRL = 12'h000;
    localparam logic [11:0] PSR_OFF_STAT = 12'h004;
    localparam logic [11:0] PSR_OFF_DATA = 12'h008;
    localparam int PSR_CTRL_GO  = 8;
    localparam int PSR_CTRL_CLR = 9;
    localparam int PSR_STAT_BUSY = 0;
    localparam int PSR_STAT_DONE = 1;
    localparam int PSR_STAT_ERR  = 2;

endpackage : psr_pkg

// [psr_sticky.sv]
// bank of sticky status bits, set wins over clear
`timescale 1ns/1ps
module psr_sticky #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] set,
    input  wire logic         clr,
    output logic      [W-1:0] q
);
    logic [W-1:0] q_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= '0;
        end else begin
            q_r <= (q_r & ~{W{clr}}) | set;
        end
    end

    assign q = q_r;
endmodule : psr_sticky
